// ---- core/sirq_core.sv ----
// serial channel: status flags, request outputs, receive errors and link shifters
//
// Behaviour
// - four separate request outputs: tx done, rx error, rx full, tx empty.
// - tx empty request follows empty flag, triggers dma; dma buffer write clears flag.
// - rx full request follows full flag, triggers dma; dma buffer read clears flag.
// - rx error request from overrun, framing or parity flag; never a dma trigger.
// - tx done request from tx done flag; never a dma trigger.
// - priority rx error, rx full, tx empty, tx done lowest.
// - requests gated by tx empty, rx and tx done enable bits.
// - moving buffer to shifter sets empty flag; writes always accepted, may overwrite.
// - overrun keeps full flag, sets overrun, drops data; other errors still transfer.
// - coinciding errors all set together; transfer suppressed exactly on overrun.
// - during break receiver keeps running; framing flag sets again after clearing.
// - synchronous mode: no transmit start while error flags set; rx disable keeps flags.
// - asynchronous receive on 16x clock, start edge sync, latch on eighth tick.
// - external clock rx disabled late at bit 7 sets full flag, no copy.
// - internal clock rx disabled late at bit 7 sets full flag, no copy.
// - synchronous mode: at final bit, empty flag 1 sets tx done flag and holds line level.
// - overrun error request gated by the rx enable shared with rx full.
`timescale 1ns/100ps
`include "sirq_params.svh"
module sirq_core (
	// system clock domain
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic sys_ce,
	// control bits
	input wire logic tx_enable,
	input wire logic rx_enable,
	input wire logic sync_mode,
	input wire logic parity_en,
	input wire logic parity_odd,
	input wire logic tx_empty_irq_en,
	input wire logic rx_irq_en,
	input wire logic tx_done_irq_en,
	// host and dma accesses
	input wire logic cpu_tx_wr,
	input wire logic dma_tx_wr,
	input wire logic [7:0] tx_wdata,
	input wire logic tx_empty_clr,
	input wire logic dma_rx_rd,
	input wire logic rx_full_clr,
	input wire logic overrun_clr,
	input wire logic framing_clr,
	input wire logic parity_clr,
	input wire logic tx_done_clr,
	// status
	output logic tx_buf_empty_flag,
	output logic rx_buf_full_flag,
	output logic overrun_flag,
	output logic framing_err_flag,
	output logic parity_err_flag,
	output logic tx_done_flag,
	output logic [7:0] rx_buf_reg,
	// requests
	output logic tx_done_irq,
	output logic rx_error_irq,
	output logic rx_full_irq,
	output logic tx_empty_irq,
	output logic tx_dma_req,
	output logic rx_dma_req,
	output sirq_pkg::sirq_src_t irq_top,
	// link side
	input wire logic link_clk,
	input wire logic rxd,
	output logic txd
);
	import sirq_pkg::*;

	// system side state
	logic [7:0] tx_buf_data_reg;
	logic [7:0] tx_xfer_reg;
	logic [7:0] rx_data_reg;
	logic tx_empty_reg, rx_full_reg, ovr_reg, fer_reg, per_reg, tx_done_flag_reg;
	logic tx_req_tgl_reg;
	logic irq_done_reg, irq_err_reg, irq_full_reg, irq_empty_reg;
	logic dma_tx_reg, dma_rx_reg;
	sirq_src_t top_reg, top_next;

	// link side state
	logic lk_ack_tgl_reg, lk_req_seen_reg, lk_last_tgl_reg, lk_rx_tgl_reg;
	logic [9:0] lk_rx_word_reg;
	logic [7:0] lk_tx_sh_reg, lk_rx_sh_reg;
	logic [3:0] lk_tcnt_reg, lk_rcnt_reg;
	logic [2:0] lk_tbit_reg, lk_rbit_reg;
	logic lk_txd_reg, lk_rx_prev_reg, lk_brk_reg, lk_rpar_reg;
	sirq_bit_t lk_tst_reg, lk_rst_reg;

	// system to link: srst, request toggle, and config levels
	localparam int NL = 6;
	logic [NL-1:0] lk_src;
	logic [NL-1:0] lk_s1, lk_s2, lk_s3, lk_v;
	// link to system: rx toggle, last-bit toggle, ack toggle
	localparam int NY = 3;
	logic [NY-1:0] sy_src;
	logic [NY-1:0] sy_s1, sy_s2, sy_s3, sy_v, sy_old;
	// rx pin filter
	logic rx_s1, rx_s2, rx_s3, rx_f;

	assign lk_src = {srst, tx_req_tgl_reg, rx_enable, sync_mode, parity_en, parity_odd};
	assign sy_src = {lk_rx_tgl_reg, lk_last_tgl_reg, lk_ack_tgl_reg};

	// three-stage synchronisers; a bit counts once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < NL; gi++) begin : g_lk
			always_ff @(posedge link_clk) begin
				lk_s1[gi] <= lk_src[gi];
				lk_s2[gi] <= lk_s1[gi];
				lk_s3[gi] <= lk_s2[gi];
				if (lk_s2[gi] == lk_s3[gi]) lk_v[gi] <= lk_s3[gi];
			end
		end
		for (gi = 0; gi < NY; gi++) begin : g_sy
			always_ff @(posedge sys_clk) begin
				sy_s1[gi] <= sy_src[gi];
				sy_s2[gi] <= sy_s1[gi];
				sy_s3[gi] <= sy_s2[gi];
				if (sy_s2[gi] == sy_s3[gi]) sy_v[gi] <= sy_s3[gi];
			end
		end
	endgenerate

	// system side decode of link events
	logic lk_rst, l_req, l_rxen, l_sync, l_pen, l_podd;
	assign {lk_rst, l_req, l_rxen, l_sync, l_pen, l_podd} = lk_v;
	logic ev_rx, ev_last, tx_pending, any_err, tx_load;
	assign ev_rx = sy_v[2] != sy_old[2];
	assign ev_last = sy_v[1] != sy_old[1];
	assign tx_pending = tx_req_tgl_reg != sy_v[0];
	assign any_err = ovr_reg | fer_reg | per_reg;
	// only one word in flight; in synchronous mode receive errors block a start
	assign tx_load = sys_ce & tx_enable & ~tx_empty_reg & ~tx_pending
		& ~(sync_mode & any_err);

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sy_old <= '0;
		end else if (sys_ce) begin
			sy_old <= sy_v;
		end
	end

	// tx buffer: every write lands, even over an unsent byte
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			tx_buf_data_reg <= 8'h00;
		end else if (sys_ce && (cpu_tx_wr || dma_tx_wr)) begin
			tx_buf_data_reg <= tx_wdata;
		end
	end

	// hand the byte to the link; the word is held stable until the next toggle
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			tx_xfer_reg <= 8'h00;
			tx_req_tgl_reg <= 1'b0;
		end else if (tx_load) begin
			tx_xfer_reg <= tx_buf_data_reg;
			tx_req_tgl_reg <= ~tx_req_tgl_reg;
		end
	end

	// empty flag: set on the move to the shifter wins over any clear
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			tx_empty_reg <= 1'b1;
		end else if (sys_ce) begin
			if (tx_load || !tx_enable) begin
				tx_empty_reg <= 1'b1;
			end else if (dma_tx_wr || tx_empty_clr) begin
				tx_empty_reg <= 1'b0;
			end
		end
	end

	// tx done: final bit seen with nothing queued behind it
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			tx_done_flag_reg <= 1'b1;
		end else if (sys_ce) begin
			if (ev_last && tx_empty_reg && !tx_pending && !tx_load) begin
				tx_done_flag_reg <= 1'b1;
			end else if (tx_load || tx_done_clr) begin
				tx_done_flag_reg <= 1'b0;
			end
		end
	end

	// receive completion, error flags and rx buffer
	logic rx_take, rx_ovr, rx_fe, rx_pe;
	assign rx_take = sys_ce & ev_rx & ~(sync_mode & any_err);
	assign rx_ovr = rx_full_reg;
	assign rx_fe = lk_rx_word_reg[8];
	assign rx_pe = lk_rx_word_reg[9];

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rx_full_reg <= 1'b0;
		end else if (sys_ce) begin
			if (rx_take && (!rx_enable || (!rx_fe && !rx_pe))) begin
				rx_full_reg <= 1'b1;
			end else if (dma_rx_rd || rx_full_clr) begin
				rx_full_reg <= 1'b0;
			end
		end
	end

	// all coinciding errors set together; hardware set beats software clear
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ovr_reg <= 1'b0;
			fer_reg <= 1'b0;
			per_reg <= 1'b0;
		end else if (sys_ce) begin
			if (rx_take && rx_enable && rx_ovr) ovr_reg <= 1'b1;
			else if (overrun_clr) ovr_reg <= 1'b0;
			if (rx_take && rx_enable && rx_fe) fer_reg <= 1'b1;
			else if (framing_clr) fer_reg <= 1'b0;
			if (rx_take && rx_enable && rx_pe) per_reg <= 1'b1;
			else if (parity_clr) per_reg <= 1'b0;
		end
	end

	// copy only when no overrun and the receiver is still enabled
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rx_data_reg <= 8'h00;
		end else if (rx_take && rx_enable && !rx_ovr) begin
			rx_data_reg <= lk_rx_word_reg[7:0];
		end
	end

	// priority among the gated requests
	always_comb begin
		top_next = SIRQ_SRC_NONE;
		if (any_err && rx_irq_en) top_next = SIRQ_SRC_RX_ERR;
		else if (rx_full_reg && rx_irq_en) top_next = SIRQ_SRC_RX_FULL;
		else if (tx_empty_reg && tx_empty_irq_en) top_next = SIRQ_SRC_TX_EMPTY;
		else if (tx_done_flag_reg && tx_done_irq_en) top_next = SIRQ_SRC_TX_DONE;
	end

	// request levels, registered one cycle behind flags and enables
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			irq_done_reg <= 1'b0;
			irq_err_reg <= 1'b0;
			irq_full_reg <= 1'b0;
			irq_empty_reg <= 1'b0;
			dma_tx_reg <= 1'b0;
			dma_rx_reg <= 1'b0;
			top_reg <= SIRQ_SRC_NONE;
		end else if (sys_ce) begin
			irq_done_reg <= tx_done_flag_reg & tx_done_irq_en;
			irq_err_reg <= any_err & rx_irq_en;
			irq_full_reg <= rx_full_reg & rx_irq_en;
			irq_empty_reg <= tx_empty_reg & tx_empty_irq_en;
			// dma may only start from the two data requests
			dma_tx_reg <= tx_empty_reg & tx_empty_irq_en;
			dma_rx_reg <= rx_full_reg & rx_irq_en;
			top_reg <= top_next;
		end
	end

	// outputs, each straight from its flop
	assign tx_buf_empty_flag = tx_empty_reg;
	assign rx_buf_full_flag = rx_full_reg;
	assign overrun_flag = ovr_reg;
	assign framing_err_flag = fer_reg;
	assign parity_err_flag = per_reg;
	assign tx_done_flag = tx_done_flag_reg;
	assign rx_buf_reg = rx_data_reg;
	assign tx_done_irq = irq_done_reg;
	assign rx_error_irq = irq_err_reg;
	assign rx_full_irq = irq_full_reg;
	assign tx_empty_irq = irq_empty_reg;
	assign tx_dma_req = dma_tx_reg;
	assign rx_dma_req = dma_rx_reg;
	assign irq_top = top_reg;
	assign txd = lk_txd_reg;

	// rx pin filter on the link clock
	always_ff @(posedge link_clk) begin
		rx_s1 <= rxd;
		rx_s2 <= rx_s1;
		rx_s3 <= rx_s2;
		if (rx_s2 == rx_s3) rx_f <= rx_s3;
	end

	// link transmitter: async ticks at 16x, sync shifts one bit per edge
	logic t_tick, t_new;
	assign t_tick = l_sync || (lk_tcnt_reg == `SIRQ_LAST_TICK);
	assign t_new = l_req != lk_req_seen_reg;

	always_ff @(posedge link_clk) begin
		if (lk_rst) begin
			lk_tst_reg <= SIRQ_B_IDLE;
			lk_tcnt_reg <= 4'h0;
			lk_tbit_reg <= 3'h0;
			lk_tx_sh_reg <= 8'h00;
			lk_txd_reg <= 1'b1;
			lk_req_seen_reg <= 1'b0;
			lk_ack_tgl_reg <= 1'b0;
			lk_last_tgl_reg <= 1'b0;
		end else begin
			lk_tcnt_reg <= (lk_tst_reg == SIRQ_B_IDLE) ? 4'h0 : lk_tcnt_reg + 4'h1;
			unique case (lk_tst_reg)
				SIRQ_B_IDLE: begin
					if (t_new) begin
						lk_tx_sh_reg <= tx_xfer_reg;
						lk_req_seen_reg <= l_req;
						lk_ack_tgl_reg <= ~lk_ack_tgl_reg;
						lk_tbit_reg <= 3'h0;
						lk_txd_reg <= l_sync ? tx_xfer_reg[0] : 1'b0;
						lk_tst_reg <= l_sync ? SIRQ_B_DATA : SIRQ_B_START;
						if (l_sync) lk_tx_sh_reg <= {1'b0, tx_xfer_reg[7:1]};
					end
				end
				SIRQ_B_START: begin
					if (t_tick) begin
						lk_txd_reg <= lk_tx_sh_reg[0];
						lk_tx_sh_reg <= {1'b0, lk_tx_sh_reg[7:1]};
						lk_tst_reg <= SIRQ_B_DATA;
					end
				end
				SIRQ_B_DATA: begin
					if (t_tick) begin
						lk_tbit_reg <= lk_tbit_reg + 3'h1;
						if (lk_tbit_reg == `SIRQ_LAST_BIT - 3'h1 && l_sync) begin
							lk_last_tgl_reg <= ~lk_last_tgl_reg;
						end
						if (lk_tbit_reg == `SIRQ_LAST_BIT) begin
							lk_txd_reg <= ~l_pen; // parity slot goes out as 0, else stop
							lk_tst_reg <= l_sync ? SIRQ_B_IDLE : (l_pen ? SIRQ_B_PAR : SIRQ_B_STOP);
							if (l_sync) lk_txd_reg <= lk_txd_reg; // hold last level
						end else begin
							lk_txd_reg <= lk_tx_sh_reg[0];
							lk_tx_sh_reg <= {1'b0, lk_tx_sh_reg[7:1]};
						end
					end
				end
				SIRQ_B_PAR: begin
					if (t_tick) begin
						lk_txd_reg <= 1'b1;
						lk_tst_reg <= SIRQ_B_STOP;
					end
				end
				SIRQ_B_STOP: begin
					if (lk_tcnt_reg == 4'h0) lk_last_tgl_reg <= ~lk_last_tgl_reg;
					if (t_tick) lk_tst_reg <= SIRQ_B_IDLE;
				end
			endcase
		end
	end

	// link receiver: start edge restarts the 16x count, sample on the eighth tick
	logic r_edge, r_tick;
	assign r_edge = (lk_rx_prev_reg || lk_brk_reg) && !rx_f;
	assign r_tick = l_sync || (lk_rcnt_reg == `SIRQ_LAST_TICK);

	always_ff @(posedge link_clk) begin
		if (lk_rst) begin
			lk_rst_reg <= SIRQ_B_IDLE;
			lk_rcnt_reg <= 4'h0;
			lk_rbit_reg <= 3'h0;
			lk_rx_sh_reg <= 8'h00;
			lk_rx_prev_reg <= 1'b1;
			lk_brk_reg <= 1'b0;
			lk_rpar_reg <= 1'b0;
			lk_rx_word_reg <= 10'h000;
			lk_rx_tgl_reg <= 1'b0;
		end else begin
			lk_rx_prev_reg <= rx_f;
			lk_rcnt_reg <= lk_rcnt_reg + 4'h1;
			unique case (lk_rst_reg)
				SIRQ_B_IDLE: begin
					lk_rbit_reg <= 3'h0;
					lk_rcnt_reg <= 4'h0;
					if (l_rxen && l_sync) begin
						lk_rx_sh_reg <= {rx_f, lk_rx_sh_reg[7:1]};
						lk_rbit_reg <= 3'h1;
						lk_rst_reg <= SIRQ_B_DATA;
					end else if (l_rxen && r_edge) begin
						lk_rst_reg <= SIRQ_B_START;
					end
				end
				SIRQ_B_START: begin
					if (lk_rcnt_reg == `SIRQ_SAMPLE_TICK) begin
						lk_rcnt_reg <= 4'h0; // later samples fall mid-bit
						lk_rst_reg <= rx_f ? SIRQ_B_IDLE : SIRQ_B_DATA;
					end
				end
				SIRQ_B_DATA: begin
					if (r_tick) begin
						lk_rx_sh_reg <= {rx_f, lk_rx_sh_reg[7:1]};
						lk_rbit_reg <= lk_rbit_reg + 3'h1;
						if (lk_rbit_reg == `SIRQ_LAST_BIT) begin
							if (l_sync) begin
								lk_rx_word_reg <= {2'b00, rx_f, lk_rx_sh_reg[7:1]};
								lk_rx_tgl_reg <= ~lk_rx_tgl_reg;
								lk_rst_reg <= SIRQ_B_IDLE;
							end else begin
								lk_rst_reg <= l_pen ? SIRQ_B_PAR : SIRQ_B_STOP;
							end
						end
					end
				end
				SIRQ_B_PAR: begin
					if (r_tick) begin
						lk_rpar_reg <= (^{lk_rx_sh_reg, rx_f}) != l_podd;
						lk_rst_reg <= SIRQ_B_STOP;
					end
				end
				SIRQ_B_STOP: begin
					if (r_tick) begin
						// a low stop bit is a framing error; a break keeps retriggering
						lk_rx_word_reg <= {lk_rpar_reg & l_pen, ~rx_f, lk_rx_sh_reg};
						lk_rx_tgl_reg <= ~lk_rx_tgl_reg;
						lk_brk_reg <= ~rx_f;
						lk_rpar_reg <= 1'b0;
						lk_rst_reg <= SIRQ_B_IDLE;
					end
				end
			endcase
		end
	end
endmodule

// ---- inc/sirq_params.svh ----
// constants for the serial channel status, request and error logic
`ifndef SIRQ_PARAMS_SVH
`define SIRQ_PARAMS_SVH

`define SIRQ_DATA_BITS 8
`define SIRQ_OVERSAMPLE 16
`define SIRQ_SAMPLE_TICK 4'h7
`define SIRQ_LAST_TICK 4'hf
`define SIRQ_LAST_BIT 3'h7
`define SIRQ_SYNC_STAGES 3

`endif

// ---- inc/sirq_pkg.sv ----
// types shared by the serial channel status, request and error logic
package sirq_pkg;
	typedef enum logic [2:0] {
		SIRQ_SRC_NONE,
		SIRQ_SRC_TX_DONE,
		SIRQ_SRC_TX_EMPTY,
		SIRQ_SRC_RX_FULL,
		SIRQ_SRC_RX_ERR
	} sirq_src_t;
	typedef enum logic [2:0] {
		SIRQ_B_IDLE,
		SIRQ_B_START,
		SIRQ_B_DATA,
		SIRQ_B_PAR,
		SIRQ_B_STOP
	} sirq_bit_t;
endpackage

// ---- sim/sirq_core_asserts.sv ----
// checker: request, dma and receive error relations of the serial channel
`timescale 1ns/100ps
module sirq_core_asserts (
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic sys_ce,
	// enables and strobes
	input wire logic tx_empty_irq_en,
	input wire logic rx_irq_en,
	input wire logic tx_done_irq_en,
	input wire logic dma_tx_wr,
	input wire logic dma_rx_rd,
	// flags
	input wire logic tx_buf_empty_flag,
	input wire logic rx_buf_full_flag,
	input wire logic overrun_flag,
	input wire logic framing_err_flag,
	input wire logic parity_err_flag,
	input wire logic tx_done_flag,
	input wire logic [7:0] rx_buf_reg,
	// requests
	input wire logic tx_done_irq,
	input wire logic rx_error_irq,
	input wire logic rx_full_irq,
	input wire logic tx_empty_irq,
	input wire logic tx_dma_req,
	input wire logic rx_dma_req,
	input wire sirq_pkg::sirq_src_t irq_top
);
	import sirq_pkg::*;
	// a frozen clock enable holds all flags, requests and buffers, so checks pause with it
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (srst || !sys_ce);

	// each request is its flag gated by its enable, one edge later
	a_tx_empty_req: assert property (tx_empty_irq == $past(tx_buf_empty_flag && tx_empty_irq_en))
		else $error("tx empty request wrong");
	a_rx_full_req: assert property (rx_full_irq == $past(rx_buf_full_flag && rx_irq_en))
		else $error("rx full request wrong");
	a_rx_err_req: assert property (rx_error_irq ==
		$past((overrun_flag || framing_err_flag || parity_err_flag) && rx_irq_en))
		else $error("rx error request wrong");
	a_tx_done_req: assert property (tx_done_irq == $past(tx_done_flag && tx_done_irq_en))
		else $error("tx done request wrong");
	// only the two data requests may start a transfer
	a_dma_follow: assert property (tx_dma_req == tx_empty_irq && rx_dma_req == rx_full_irq)
		else $error("dma request mismatch");
	a_dma_wr_clr: assert property (dma_tx_wr && tx_buf_empty_flag |=> !tx_buf_empty_flag)
		else $error("dma write left empty flag");
	a_dma_rd_clr: assert property (dma_rx_rd && rx_buf_full_flag |=> !rx_buf_full_flag)
		else $error("dma read left full flag");
	// priority is judged only once the requests have settled
	a_prio_err: assert property (rx_error_irq && $past(rx_error_irq) |-> irq_top == SIRQ_SRC_RX_ERR)
		else $error("error request not on top");
	a_prio_full: assert property (rx_full_irq && !rx_error_irq && $past(rx_full_irq && !rx_error_irq)
		|-> irq_top == SIRQ_SRC_RX_FULL)
		else $error("full request not on top");
	// overrun drops the byte: buffer unchanged and full kept
	a_ovr_keep: assert property ($rose(overrun_flag) |-> rx_buf_full_flag
		&& rx_buf_reg == $past(rx_buf_reg, 8))
		else $error("overrun changed rx buffer");
endmodule

bind sirq_core sirq_core_asserts u_chk (.sys_clk, .srst, .sys_ce, .tx_empty_irq_en, .rx_irq_en,
	.tx_done_irq_en, .dma_tx_wr, .dma_rx_rd, .tx_buf_empty_flag, .rx_buf_full_flag, .overrun_flag,
	.framing_err_flag, .parity_err_flag, .tx_done_flag, .rx_buf_reg, .tx_done_irq, .rx_error_irq,
	.rx_full_irq, .tx_empty_irq, .tx_dma_req, .rx_dma_req, .irq_top);

// ---- sim/sirq_peer.sv ----
// remote serial peer: sends frames on the receive line, decodes the transmit line
`timescale 1ns/100ps
module sirq_peer (
	// link side
	input wire logic link_clk,
	input wire logic txd,
	output logic rxd
);
	logic [7:0] got;

	// an asynchronous line idles high
	initial begin
		rxd = 1'b1;
		got = 8'h00;
	end

	// start, 8 bits lsb first, stop; 16 base clocks a bit
	task automatic send(input logic [7:0] d, input logic stp);
		logic [9:0] f;
		f = {stp, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge link_clk);
			rxd <= f[i];
			repeat (15) @(posedge link_clk);
		end
		@(posedge link_clk);
		rxd <= 1'b1;
	endtask

	// hold the line at one level, low for a break
	task automatic hold(input logic v);
		@(posedge link_clk);
		rxd <= v;
	endtask

	// sample transmitted bits at mid-bit
	always begin
		@(negedge txd);
		repeat (24) @(posedge link_clk);
		for (int i = 0; i < 8; i++) begin
			got[i] = txd;
			repeat (16) @(posedge link_clk);
		end
	end
endmodule

// ---- sim/tb_top.sv ----
// testbench: flags, requests, dma clears and receive errors of the serial channel
`timescale 1ns/100ps
module tb_top;
	import sirq_pkg::*;
	logic sys_clk, srst, sys_ce, tx_enable, rx_enable, sync_mode, parity_en, parity_odd;
	logic tx_empty_irq_en, rx_irq_en, tx_done_irq_en, cpu_tx_wr, dma_tx_wr, tx_empty_clr;
	logic dma_rx_rd, rx_full_clr, overrun_clr, framing_clr, parity_clr, tx_done_clr;
	logic [7:0] tx_wdata, rx_buf_reg;
	logic tx_buf_empty_flag, rx_buf_full_flag, overrun_flag, framing_err_flag, parity_err_flag;
	logic tx_done_flag, tx_done_irq, rx_error_irq, rx_full_irq, tx_empty_irq, tx_dma_req;
	logic rx_dma_req, link_clk, rxd, txd;
	sirq_src_t irq_top;
	int bad_count = 0;
	int checked = 0;
	logic link_run = 1'b1;

	sirq_core u_dut (.sys_clk, .srst, .sys_ce, .tx_enable, .rx_enable, .sync_mode, .parity_en,
		.parity_odd, .tx_empty_irq_en, .rx_irq_en, .tx_done_irq_en, .cpu_tx_wr, .dma_tx_wr,
		.tx_wdata, .tx_empty_clr, .dma_rx_rd, .rx_full_clr, .overrun_clr, .framing_clr,
		.parity_clr, .tx_done_clr, .tx_buf_empty_flag, .rx_buf_full_flag, .overrun_flag,
		.framing_err_flag, .parity_err_flag, .tx_done_flag, .rx_buf_reg, .tx_done_irq,
		.rx_error_irq, .rx_full_irq, .tx_empty_irq, .tx_dma_req, .rx_dma_req, .irq_top,
		.link_clk, .rxd, .txd);
	sirq_peer u_peer (.link_clk, .txd, .rxd);

	// system clock
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	// link clock, offset so its edges drift against the system clock; idles high when stopped
	initial begin
		link_clk = 1'b0;
		#3;
		forever #6 link_clk = link_run ? ~link_clk : 1'b1;
	end

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	// one-cycle strobe, raised and dropped on falling edges
	task automatic st(input int k);
		@(negedge sys_clk);
		case (k)
			0: dma_tx_wr = 1'b1;
			1: dma_rx_rd = 1'b1;
			2: overrun_clr = 1'b1;
			3: framing_clr = 1'b1;
			4: tx_done_clr = 1'b1;
			5: cpu_tx_wr = 1'b1;
			6: rx_full_clr = 1'b1;
			8: tx_empty_clr = 1'b1;
			default: parity_clr = 1'b1;
		endcase
		@(negedge sys_clk);
		{cpu_tx_wr, dma_tx_wr, dma_rx_rd, rx_full_clr, overrun_clr, framing_clr, parity_clr,
			tx_done_clr, tx_empty_clr} = 9'h000;
	endtask

	task automatic test_done;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// watchdog: the whole run needs under 1000 system clocks
	initial begin
		repeat (4000) @(posedge sys_clk);
		bad_count++;
		test_done;
	end

	initial begin
		{sync_mode, parity_en, parity_odd, tx_empty_clr} = 4'h0;
		{tx_enable, rx_enable, tx_empty_irq_en, rx_irq_en, tx_done_irq_en} = 5'h00;
		{cpu_tx_wr, dma_tx_wr, dma_rx_rd, rx_full_clr, overrun_clr, framing_clr, parity_clr,
			tx_done_clr} = 8'h00;
		tx_wdata = 8'h00;
		sys_ce = 1'b1;
		srst = 1'b1;
		repeat (5) @(negedge sys_clk);
		srst = 1'b0;
		wt(10);
		chk("empty", tx_buf_empty_flag, 8'h01);
		chk("full", rx_buf_full_flag, 8'h00);
		chk("txd", txd, 8'h01);
		{tx_enable, rx_enable, tx_empty_irq_en, rx_irq_en, tx_done_irq_en} = 5'h1f;
		wt(2);
		chk("txe req", tx_empty_irq, 8'h01);
		chk("tx dma", tx_dma_req, 8'h01);
		chk("done req", tx_done_irq, 8'h01);
		chk("top", irq_top, SIRQ_SRC_TX_EMPTY);
		// dma write clears empty; the load sets it again
		tx_wdata = 8'ha5;
		st(0);
		chk("empty", tx_buf_empty_flag, 8'h00);
		wt(70);
		chk("tx byte", u_peer.got, 8'ha5);
		chk("empty", tx_buf_empty_flag, 8'h01);
		chk("done", tx_done_flag, 8'h01);
		st(4);
		wt(2);
		chk("done req", tx_done_irq, 8'h00);
		chk("empty", tx_buf_empty_flag, 8'h01);
		tx_wdata = 8'h96;
		st(5);
		st(8); // a host write leaves the flag to software
		wt(70);
		chk("tx byte", u_peer.got, 8'h96);
		chk("done req", tx_done_irq, 8'h01);
		// clean frame, then overrun
		u_peer.send(8'h3c, 1'b1);
		wt(8);
		chk("full", rx_buf_full_flag, 8'h01);
		chk("rx byte", rx_buf_reg, 8'h3c);
		chk("rx dma", rx_dma_req, 8'h01);
		chk("top", irq_top, SIRQ_SRC_RX_FULL);
		u_peer.send(8'hc3, 1'b1);
		wt(8);
		chk("overrun", overrun_flag, 8'h01);
		chk("full", rx_buf_full_flag, 8'h01);
		chk("rx byte", rx_buf_reg, 8'h3c);
		chk("err req", rx_error_irq, 8'h01);
		chk("top", irq_top, SIRQ_SRC_RX_ERR);
		rx_irq_en = 1'b0;
		wt(2);
		chk("err req", rx_error_irq, 8'h00);
		chk("rxf req", rx_full_irq, 8'h00);
		rx_irq_en = 1'b1;
		// dma read only once the full request is pending
		st(1);
		st(2);
		wt(2);
		chk("full", rx_buf_full_flag, 8'h00);
		chk("err req", rx_error_irq, 8'h00);
		// framing alone copies; with overrun nothing is copied
		u_peer.send(8'h5a, 1'b0);
		wt(8);
		chk("framing", framing_err_flag, 8'h01);
		chk("full", rx_buf_full_flag, 8'h00);
		chk("rx byte", rx_buf_reg, 8'h5a);
		chk("rx dma", rx_dma_req, 8'h00);
		st(3);
		u_peer.send(8'h11, 1'b1);
		u_peer.send(8'h22, 1'b0);
		wt(8);
		chk("overrun", overrun_flag, 8'h01);
		chk("framing", framing_err_flag, 8'h01);
		chk("rx byte", rx_buf_reg, 8'h11);
		st(6);
		st(2);
		st(3);
		st(7);
		// the stop slot of the peer frame becomes the parity bit; odd sum fails even parity
		parity_en = 1'b1;
		u_peer.send(8'h01, 1'b0);
		wt(12);
		chk("parity", parity_err_flag, 8'h01);
		chk("rx byte", rx_buf_reg, 8'h01);
		chk("full", rx_buf_full_flag, 8'h00);
		chk("err req", rx_error_irq, 8'h01);
		parity_en = 1'b0;
		st(7);
		// break: framing sets again after it is cleared
		u_peer.hold(1'b0);
		wt(80);
		chk("framing", framing_err_flag, 8'h01);
		st(3);
		wt(80);
		chk("framing", framing_err_flag, 8'h01);
		rx_enable = 1'b0;
		u_peer.hold(1'b1);
		wt(4);
		chk("framing", framing_err_flag, 8'h01);
		// synchronous mode: an error flag holds back the start; clock waits after the dma write
		link_run = 1'b0;
		sync_mode = 1'b1;
		tx_wdata = 8'h69;
		st(0);
		wt(24);
		chk("empty", tx_buf_empty_flag, 8'h00);
		st(3);
		wt(2);
		chk("empty", tx_buf_empty_flag, 8'h01);
		chk("done", tx_done_flag, 8'h00);
		link_run = 1'b1;
		wt(16);
		chk("done", tx_done_flag, 8'h01);
		chk("txd", txd, 8'h00);
		test_done;
	end
endmodule
